// ===== design/iox_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module iox_buf2 #(
    parameter int W = 11
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    logic [1:0]   fill;
    logic         push;
    logic         pop;

    // Honest full/empty straight from the fill count
    assign in_ready  = (fill != 2'h2);
    assign out_valid = (fill != 2'h0);
    assign out_data  = slot0;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Occupancy
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fill <= 2'h0;
        end else if (push && !pop) begin
            fill <= fill + 2'h1;
        end else if (pop && !push) begin
            fill <= fill - 2'h1;
        end
    end

    // Slot 0 is always the head; slot 1 shifts down on a pop
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            slot0 <= '0;
            slot1 <= '0;
        end else begin
            if (pop) begin
                slot0 <= (fill == 2'h2) ? slot1 : in_data;
            end else if (push && fill == 2'h0) begin
                slot0 <= in_data;
            end
            if (push && ((fill == 2'h1 && !pop) || fill == 2'h2)) begin
                slot1 <= in_data;
            end
        end
    end

endmodule

// ===== design/iox_pkg.sv
// Shared constants for the two-wire 16-bit port expander slave.
// Assumes one clock domain (mclk) for every user of this package.
package iox_pkg;

    // Fixed upper four bits of the 7-bit slave address
    localparam logic [3:0] ADDR_HI = 4'h4;

    // Command pointer values, one per 8-bit register
    localparam logic [2:0] REG_IN0  = 3'h0;
    localparam logic [2:0] REG_IN1  = 3'h1;
    localparam logic [2:0] REG_OUT0 = 3'h2;
    localparam logic [2:0] REG_OUT1 = 3'h3;
    localparam logic [2:0] REG_POL0 = 3'h4;
    localparam logic [2:0] REG_POL1 = 3'h5;
    localparam logic [2:0] REG_CFG0 = 3'h6;
    localparam logic [2:0] REG_CFG1 = 3'h7;

    // Pair selector: pointer bits [2:1]
    localparam logic [1:0] PAIR_IN  = 2'h0;
    localparam logic [1:0] PAIR_OUT = 2'h1;
    localparam logic [1:0] PAIR_POL = 2'h2;

    // Reset values
    localparam logic [15:0] OUT_RST = 16'hffff;
    localparam logic [15:0] POL_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'hffff;

    // Bits in a byte and cycles for pin synchronisers to settle
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] SETTLE    = 2'h3;

    // Write buffer entry: {pointer[2:0], data[7:0]}
    localparam int BUF_W = 11;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ACK  = 6'h04,
        ST_RX   = 6'h08,
        ST_TX   = 6'h10,
        ST_MACK = 6'h20
    } iox_state_t;

endpackage

// ===== design/iox_slave.sv
// Two-wire bus slave of a 16-bit port expander: paired registers,
// command pointer, acknowledge handling and per-port change interrupt.
// Assumes bus pins and port pins are asynchronous to mclk; open-drain
// outputs are resolved outside (oe high pulls the wire low).
//
// Functional notes
// - First written byte sets the command pointer
// - After each write, pointer toggles within pair
// - Unlimited write bytes alternate within the pair
// - Read returns pointer register, then alternates pair
// - Read data captured at acknowledge falling edge
// - STOP accepted anywhere; applied writes stay valid
// - Interrupt low when an input pin changes
// - Cleared by return to level or port read
// - Output-configured pins never raise the interrupt
// - Interrupt clearing is tracked per 8-bit port
// - Output-to-input switch with mismatch may interrupt
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Data changes only while clock low
// - Acknowledge every byte when addressed as receiver; a full write buffer refuses the byte with no acknowledge
// - Acknowledger holds data low through ninth pulse
// - On master no-acknowledge, release data line
// - Pointer 0-1 input, 2-3 output, 4-5 polarity, 6-7 config
// - Input registers ignore writes; read live pins
// - Polarity bit inverts read; config one is input
`timescale 1ns/1ps
module iox_slave (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Two-wire bus pins
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Address select pins
    input  wire logic [2:0]  addr_sel,
    // Port pins
    input  wire logic [15:0] io_in,
    output logic [15:0]      io_out,
    output logic [15:0]      io_oe,
    // Open-drain interrupt, active low on the wire
    output logic             int_n_out,
    output logic             int_n_oe
);

    iox_pkg::iox_state_t state;

    // Synchronisers: first stage is read only by the second
    logic [20:0] meta;
    logic [20:0] sync;
    logic        scl_s;
    logic        sda_s;
    logic [2:0]  sel_s;
    logic [15:0] pin_s;
    logic        scl_d;
    logic        sda_d;

    // Bus condition detection
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;

    // Transfer state
    logic [7:0]  shreg;
    logic [3:0]  bitcnt;
    logic        rnw;
    logic        have_cmd;
    logic        m_ack;
    logic [2:0]  ptr;
    logic        byte_done;
    logic        addr_hit;

    // Registers
    logic [15:0] outp;
    logic [15:0] pol;
    logic [15:0] cfg;
    logic [15:0] in_snap;
    logic [1:0]  settle;

    // Read path
    logic        load_tx;
    logic [2:0]  load_idx;
    logic [7:0]  rd_byte;
    logic [1:0]  port_pend;

    // Write buffer
    logic        bf_in_valid;
    logic        bf_in_ready;
    logic        bf_out_valid;
    logic        bf_out_ready;
    logic [10:0] bf_out_data;

    // Two flops on every pin input before any logic looks at it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta <= 21'h18_0000; // Bus wires rest high: no false edge
            sync <= 21'h18_0000;
        end else begin
            meta <= {scl, sda_in, addr_sel, io_in};
            sync <= meta;
        end
    end

    assign scl_s = sync[20];
    assign sda_s = sync[19];
    assign sel_s = sync[18:16];
    assign pin_s = sync[15:0];

    // Previous synchronised levels for edge finding
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise   = scl_s && !scl_d;
    assign scl_fall   = !scl_s && scl_d;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s;
    assign stop_cond  = scl_s && scl_d && !sda_d && sda_s;

    assign byte_done = scl_fall && (bitcnt == iox_pkg::BYTE_BITS);
    assign addr_hit  = (shreg[7:1] == {iox_pkg::ADDR_HI, sel_s});

    // Read captures happen on the falling edge that ends an acknowledge
    assign load_tx = scl_fall
                     && ((state == iox_pkg::ST_ACK && rnw)
                         || (state == iox_pkg::ST_MACK && m_ack));
    assign load_idx = (state == iox_pkg::ST_MACK) ? {ptr[2:1], ~ptr[0]}
                                                  : ptr;

    // Read data selection by pointer pair
    always_comb begin
        case (load_idx[2:1])
            iox_pkg::PAIR_IN:
                rd_byte = pin_s[{load_idx[0], 3'h0} +: 8]
                          ^ pol[{load_idx[0], 3'h0} +: 8];
            iox_pkg::PAIR_OUT:
                rd_byte = outp[{load_idx[0], 3'h0} +: 8];
            iox_pkg::PAIR_POL:
                rd_byte = pol[{load_idx[0], 3'h0} +: 8];
            default:
                rd_byte = cfg[{load_idx[0], 3'h0} +: 8];
        endcase
    end

    // Bus state machine; start and stop override every state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= iox_pkg::ST_IDLE;
        end else if (stop_cond) begin
            state <= iox_pkg::ST_IDLE;
        end else if (start_cond) begin
            state <= iox_pkg::ST_ADDR;
        end else begin
            case (state)
                iox_pkg::ST_IDLE: begin
                    state <= iox_pkg::ST_IDLE;
                end
                iox_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        state <= addr_hit ? iox_pkg::ST_ACK
                                          : iox_pkg::ST_IDLE;
                    end
                end
                iox_pkg::ST_RX: begin
                    // A full buffer refuses the byte with no acknowledge
                    if (byte_done) begin
                        state <= (!have_cmd || bf_in_ready)
                                 ? iox_pkg::ST_ACK : iox_pkg::ST_IDLE;
                    end
                end
                iox_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state <= rnw ? iox_pkg::ST_TX : iox_pkg::ST_RX;
                    end
                end
                iox_pkg::ST_TX: begin
                    if (byte_done) begin
                        state <= iox_pkg::ST_MACK;
                    end
                end
                iox_pkg::ST_MACK: begin
                    if (scl_fall) begin
                        state <= m_ack ? iox_pkg::ST_TX
                                       : iox_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= iox_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Shift register and bit count: sample on rise, send on fall
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shreg  <= 8'h00;
            bitcnt <= 4'h0;
        end else if (start_cond || stop_cond) begin
            bitcnt <= 4'h0;
        end else if (load_tx) begin
            shreg  <= {rd_byte[6:0], 1'b0};
            bitcnt <= 4'h1;
        end else if (state == iox_pkg::ST_TX) begin
            if (scl_fall && bitcnt != iox_pkg::BYTE_BITS) begin
                shreg  <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
            end
        end else if (state == iox_pkg::ST_ADDR
                     || state == iox_pkg::ST_RX) begin
            if (scl_rise) begin
                shreg  <= {shreg[6:0], sda_s};
                bitcnt <= bitcnt + 4'h1;
            end
        end else begin
            bitcnt <= 4'h0;
        end
    end

    // Direction bit, command flag and master acknowledge sample
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rnw      <= 1'b0;
            have_cmd <= 1'b0;
            m_ack    <= 1'b0;
        end else begin
            if (start_cond) begin
                have_cmd <= 1'b0;
            end else if (state == iox_pkg::ST_RX && byte_done) begin
                have_cmd <= 1'b1;
            end
            if (state == iox_pkg::ST_ADDR && byte_done) begin
                rnw <= shreg[0];
            end
            if (state == iox_pkg::ST_MACK && scl_rise) begin
                m_ack <= !sda_s;
            end
        end
    end

    // Command pointer: set by command, toggled within its pair
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ptr <= iox_pkg::REG_IN0;
        end else if (state == iox_pkg::ST_RX && byte_done) begin
            if (!have_cmd) begin
                ptr <= shreg[2:0];
            end else if (bf_in_ready) begin
                ptr <= {ptr[2:1], ~ptr[0]};
            end
        end else if (state == iox_pkg::ST_MACK && load_tx) begin
            ptr <= load_idx;
        end
    end

    // Data line drive, changed only on falling clock
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sda_oe <= 1'b0;
        end else if (start_cond || stop_cond) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            case (state)
                iox_pkg::ST_ADDR: begin
                    sda_oe <= bitcnt == iox_pkg::BYTE_BITS && addr_hit;
                end
                iox_pkg::ST_RX: begin
                    sda_oe <= bitcnt == iox_pkg::BYTE_BITS
                              && (!have_cmd || bf_in_ready);
                end
                iox_pkg::ST_ACK: begin
                    sda_oe <= rnw && !rd_byte[7];
                end
                iox_pkg::ST_TX: begin
                    sda_oe <= bitcnt != iox_pkg::BYTE_BITS
                              && !shreg[7];
                end
                iox_pkg::ST_MACK: begin
                    sda_oe <= m_ack && !rd_byte[7];
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;

    // Written bytes queue here so a busy register file drops nothing
    assign bf_in_valid = state == iox_pkg::ST_RX && byte_done
                         && have_cmd;
    // Register file stalls draining while a read capture is in flight
    assign bf_out_ready = !load_tx;

    iox_buf2 #(
        .W(iox_pkg::BUF_W)
    ) u_wbuf (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (bf_in_valid),
        .in_ready  (bf_in_ready),
        .in_data   ({ptr, shreg}),
        .out_valid (bf_out_valid),
        .out_ready (bf_out_ready),
        .out_data  (bf_out_data)
    );

    // Register writes; input registers take no writes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            outp <= iox_pkg::OUT_RST;
            pol  <= iox_pkg::POL_RST;
            cfg  <= iox_pkg::CFG_RST;
        end else if (bf_out_valid && bf_out_ready) begin
            case (bf_out_data[10:8])
                iox_pkg::REG_OUT0: outp[7:0]  <= bf_out_data[7:0];
                iox_pkg::REG_OUT1: outp[15:8] <= bf_out_data[7:0];
                iox_pkg::REG_POL0: pol[7:0]   <= bf_out_data[7:0];
                iox_pkg::REG_POL1: pol[15:8]  <= bf_out_data[7:0];
                iox_pkg::REG_CFG0: cfg[7:0]   <= bf_out_data[7:0];
                iox_pkg::REG_CFG1: cfg[15:8]  <= bf_out_data[7:0];
                default: begin
                end
            endcase
        end
    end

    // Port drivers: a clear config bit makes the pin an output
    assign io_out = outp;
    assign io_oe  = ~cfg;

    // Snapshot follows the pins until the synchronisers hold real data
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            settle <= 2'h0;
        end else if (settle != iox_pkg::SETTLE) begin
            settle <= settle + 2'h1;
        end
    end

    // Per-port input snapshot and change detect
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            logic rd_hit;
            assign rd_hit = load_tx && load_idx[2:1] == iox_pkg::PAIR_IN
                            && load_idx[0] == 1'(gp);
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    in_snap[gp*8 +: 8] <= 8'h00;
                end else if (settle != iox_pkg::SETTLE || rd_hit) begin
                    in_snap[gp*8 +: 8] <= pin_s[gp*8 +: 8];
                end
            end
            // Output pins refresh their snapshot only on a port read, so a later switch
            // to input with a mismatch raises the interrupt
            assign port_pend[gp] = |((pin_s[gp*8 +: 8]
                                      ^ in_snap[gp*8 +: 8])
                                     & cfg[gp*8 +: 8]);
        end
    endgenerate

    // Interrupt pin pulled low while either port has a change
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            int_n_oe <= 1'b0;
        end else begin
            int_n_oe <= |port_pend && settle == iox_pkg::SETTLE;
        end
    end

    assign int_n_out = 1'b0;

endmodule

// ===== tb/iox_master.sv
// Bus master model: drives the clock wire and pulls the data wire.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module iox_master (
    // Bus wires
    output logic     scl,
    output logic     sda_pull,
    input wire logic sda
);
    // Idle bus: both wires high, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // One 160 ns pulse; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #20 sda_pull = ~b;
        #100 scl = 1'b1;
        #20 r = sda;
        #20;
    endtask

    // START, also a repeated START from a low-clock state
    task automatic start;
        scl = 1'b0;
        #20 sda_pull = 1'b0;
        #100 scl = 1'b1;
        #100 sda_pull = 1'b1;
        #100;
    endtask

    // STOP leaves both wires released
    task automatic stop;
        scl = 1'b0;
        #20 sda_pull = 1'b1;
        #100 scl = 1'b1;
        #100 sda_pull = 1'b0;
        #100;
    endtask

    // Byte MSB first, then the acknowledge pulse
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack_out);
    endtask
endmodule

// ===== tb/iox_slave_properties.sv
// Timing relations on the expander slave's pins.
// Assumes one mclk domain; bound to every instance of the slave.
`timescale 1ns/1ps
module iox_slave_properties (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // Bus pins
    input wire logic        scl,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic [2:0]  addr_sel,
    // Port pins and interrupt
    input wire logic [15:0] io_in,
    input wire logic [15:0] io_out,
    input wire logic [15:0] io_oe,
    input wire logic        int_n_out,
    input wire logic        int_n_oe
);
    logic [4:0] in_age;
    logic [4:0] oe_age;
    logic [4:0] fall_age;
    logic [3:0] bits;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Age of the last input-pin or direction change; output pins ignored
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            in_age <= 5'h1f;
        end else if ((io_in & ~io_oe) != $past(io_in & ~io_oe)
                     || io_oe != $past(io_oe)) begin
            in_age <= 5'h00;
        end else if (in_age != 5'h1f) begin
            in_age <= in_age + 5'h01;
        end
    end

    // Age since the device last pulled the data wire
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oe_age <= 5'h1f;
        end else if (sda_oe) begin
            oe_age <= 5'h00;
        end else if (oe_age != 5'h1f) begin
            oe_age <= oe_age + 5'h01;
        end
    end

    // Age since the clock wire last fell
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fall_age <= 5'h1f;
        end else if ($past(scl) && !scl) begin
            fall_age <= 5'h00;
        end else if (fall_age != 5'h1f) begin
            fall_age <= fall_age + 5'h01;
        end
    end

    // Clock pulses since START, saturating well above one byte
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bits <= 4'h0;
        end else if (scl && $past(scl) && !sda_in && $past(sda_in)) begin
            bits <= 4'h0;
        end else if (scl && !$past(scl) && bits != 4'hf) begin
            bits <= bits + 4'h1;
        end
    end

    rst_vals_a: assert property (disable iff (1'b0)
        sys_rst |=> !sda_oe && !int_n_oe && io_out == iox_pkg::OUT_RST
        && io_oe == ~iox_pkg::CFG_RST) else $error("reset values wrong");
    od_const_a: assert property (
        sda_out == 1'b0 && int_n_out == 1'b0) else $error("open drain value");
    drive_edge_a: assert property (
        $changed(sda_oe) |-> !scl) else $error("data moved with clock high");
    drive_span_a: assert property (
        $rose(sda_oe) |-> ##[1:300] !sda_oe) else $error("data held too long");
    ack_first_a: assert property (
        $rose(sda_oe) |-> bits >= 4'h8) else $error("drive before 8 pulses");
    int_cause_a: assert property (
        $rose(int_n_oe) |-> in_age < 5'h08) else $error("interrupt no cause");
    int_clear_a: assert property (
        $fell(int_n_oe) |-> in_age < 5'h08 || fall_age < 5'h0c)
        else $error("interrupt cleared no cause");
    wr_ack_a: assert property (
        $changed(io_out) || $changed(io_oe) |-> oe_age < 5'h0c)
        else $error("register changed without acknowledge");
endmodule

bind iox_slave iox_slave_properties chk (.mclk(mclk), .sys_rst(sys_rst),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe));

// ===== tb/tb_top.sv
// Self-checking bench for the expander slave with a bus master model.
// Assumes the package, master model and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    // Clock, reset and wires
    logic        mclk;
    logic        sys_rst;
    logic        scl;
    logic        m_pull;
    wire         sda;
    wire  [15:0] io_in;
    logic        sda_oe;
    logic [2:0]  addr_sel;
    logic [15:0] ext_in;
    logic [15:0] io_out;
    logic [15:0] io_oe;
    logic        int_n_oe;
    logic [7:0]  rd [3];
    logic [7:0]  x;
    logic        ak;
    int          fail_count;
    int          check_count;

    // Pulled-up data wire; a pin shows the expander when it drives
    assign sda   = ~(m_pull | sda_oe);
    assign io_in = (io_oe & io_out) | (~io_oe & ext_in);

    iox_master m (.scl(scl), .sda_pull(m_pull), .sda(sda));
    iox_slave uut (.mclk(mclk), .sys_rst(sys_rst), .scl(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_sel(addr_sel),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .int_n_out(),
        .int_n_oe(int_n_oe));

    // 50 MHz clock
    always #10 mclk = ~mclk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Pins take about 3 cycles through the synchronisers
    task automatic settle;
        repeat (10) @(negedge mclk);
    endtask

    task automatic head(input logic [2:0] p);
        m.start();
        m.xfer({iox_pkg::ADDR_HI, addr_sel, 1'b0}, 1'b1, x, ak);
        check(ak, 1'b0);
        m.xfer({5'h00, p}, 1'b1, x, ak);
        check(ak, 1'b0);
    endtask

    task automatic wr(input logic [2:0] p, input logic [31:0] w,
                      input int n);
        head(p);
        for (int k = 0; k < n; k++) begin
            m.xfer(w[31-8*k -: 8], 1'b1, x, ak);
            check(ak, 1'b0);
        end
        m.stop();
    endtask

    // Read n bytes; the last one is left unacknowledged
    task automatic rdp(input logic [2:0] p, input int n);
        head(p);
        m.start();
        m.xfer({iox_pkg::ADDR_HI, addr_sel, 1'b1}, 1'b1, x, ak);
        check(ak, 1'b0);
        for (int k = 0; k < n; k++) begin
            m.xfer(8'hff, k == n - 1, rd[k], ak);
        end
        check(sda_oe, 1'b0);
        m.stop();
    endtask

    task automatic t_reset;
        check(io_out, iox_pkg::OUT_RST);
        check(io_oe, ~iox_pkg::CFG_RST);
        check(int_n_oe, 1'b0);
        $display("reset test done");
    endtask

    task automatic t_pair;
        wr(iox_pkg::REG_OUT1, 32'ha55a_c300, 3);
        check(io_out, 16'hc35a);
        rdp(iox_pkg::REG_OUT0, 3);
        check({rd[0], rd[1]}, 16'h5ac3);
        check(rd[2], 8'h5a);
        wr(iox_pkg::REG_CFG0, 32'h0ff0_0000, 2);
        check(io_oe, 16'h0ff0);
        settle();
        check(int_n_oe, 1'b0);
        $display("pair test done");
    endtask

    task automatic t_inputs;
        wr(iox_pkg::REG_CFG0, 32'hffff_0000, 2);
        wr(iox_pkg::REG_POL0, 32'h0f00_0000, 2);
        wr(iox_pkg::REG_IN0, 32'h1234_0000, 2);
        ext_in = 16'h3ca5;
        settle();
        rdp(iox_pkg::REG_IN1, 2);
        check({rd[0], rd[1]}, 16'h3caa);
        settle();
        check(int_n_oe, 1'b0);
        $display("input test done");
    endtask

    task automatic t_int;
        ext_in = 16'h3ca4;
        settle();
        check(int_n_oe, 1'b1);
        ext_in = 16'h3ca5;
        settle();
        check(int_n_oe, 1'b0);
        ext_in = 16'h3da4;
        settle();
        rdp(iox_pkg::REG_IN1, 1);
        settle();
        check(int_n_oe, 1'b1);
        rdp(iox_pkg::REG_IN0, 1);
        settle();
        check(int_n_oe, 1'b0);
        check(rd[0], 8'hab);
        wr(iox_pkg::REG_CFG0, 32'hfeff_0000, 2);
        // Output pin 0 now moves 0 to 1 against its snapshot
        wr(iox_pkg::REG_OUT0, 32'h5b00_0000, 1);
        ext_in = 16'h3da5;
        settle();
        check(int_n_oe, 1'b0);
        wr(iox_pkg::REG_CFG0, 32'hffff_0000, 2);
        settle();
        check(int_n_oe, 1'b1);
        rdp(iox_pkg::REG_IN0, 1);
        settle();
        check(int_n_oe, 1'b0);
        $display("interrupt test done");
    endtask

    task automatic t_addr;
        m.start();
        m.xfer({iox_pkg::ADDR_HI, addr_sel ^ 3'h1, 1'b0}, 1'b1, x, ak);
        check(ak, 1'b1);
        m.start();
        m.xfer({iox_pkg::ADDR_HI ^ 4'h1, addr_sel, 1'b0}, 1'b1, x, ak);
        check(ak, 1'b1);
        m.stop();
        addr_sel = 3'h5;
        settle();
        wr(iox_pkg::REG_OUT0, 32'h7700_0000, 1);
        check(io_out, 16'hc377);
        $display("address test done");
    endtask

    // STOP in mid-byte keeps the byte already acknowledged
    task automatic t_stop;
        head(iox_pkg::REG_OUT1);
        m.xfer(8'h99, 1'b1, x, ak);
        for (int k = 0; k < 4; k++) begin
            m.bit_io(1'b0, ak);
        end
        m.stop();
        settle();
        check(io_out, 16'h9977);
        $display("stop test done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence; every bus action stays on falling clock edges
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        addr_sel = 3'h2;
        ext_in = 16'hffff;
        fail_count = 0;
        check_count = 0;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (8) @(negedge mclk);
        t_reset();
        t_pair();
        t_inputs();
        t_int();
        t_addr();
        t_stop();
        conclude();
    end

    // Watchdog: about ten times the expected run of some 100 us
    initial begin
        #1_000_000;
        fail_count++;
        conclude();
    end
endmodule
